// [verilog/code_protect_pkg.sv]
// Package for the code-protection and identification-space block.
// Assumes 14-bit program words and 16-bit word addresses.
package code_protect_pkg;
   localparam int          WORD_W          = 14;
   localparam int          ADDR_W          = 16;
   // Identification space addresses
   localparam logic [15:0] USER_ID_FIRST   = 16'h8000;
   localparam logic [15:0] USER_ID_LAST    = 16'h8003;
   localparam logic [15:0] REVISION_ADDR   = 16'h8005;
   localparam logic [15:0] DEVICE_ID_ADDR  = 16'h8006;
   localparam logic [15:0] CONFIG4_ADDR    = 16'h8007;
   localparam logic [15:0] PROT_CFG_ADDR   = 16'h800b;
   localparam logic [15:0] FACTORY_FIRST   = 16'h8100;
   localparam logic [15:0] FACTORY_LAST    = 16'h811f;
   localparam logic [15:0] TEMP_LOW_ADDR   = 16'h8113;
   localparam logic [15:0] TEMP_HIGH_ADDR  = 16'h8116;
   localparam logic [15:0] REF_FIRST_ADDR  = 16'h8118;
   localparam logic [15:0] ADC_REF4X_ADDR  = 16'h811a;
   localparam logic [15:0] CMP_REF4X_ADDR  = 16'h811d;
   localparam logic [15:0] REF_LAST_ADDR   = 16'h811d;
   // Code protection word layout
   localparam int          PROT_BIT        = 0;
   localparam logic [12:0] PROT_SPARE_ONES = 13'h1fff;
   // Write-protection bit positions in the memory configuration word
   localparam int          WP_STORE_BIT    = 11;
   localparam int          WP_CFG_BIT      = 9;
   localparam int          WP_BOOT_BIT     = 8;
   localparam int          WP_APP_BIT      = 7;
   localparam logic [13:0] CONFIG4_RESET   = 14'h3fff;
   // Revision word layout
   localparam logic [1:0]  REV_FIXED       = 2'h2;
   localparam int          REV_MAJOR_LSB   = 6;
   // Program memory region codes
   typedef enum logic [1:0] {
      REGION_APP  = 2'b00,
      REGION_STORE = 2'b01,
      REGION_BOOT = 2'b10,
      REGION_CFG  = 2'b11
   } region_t;
endpackage

// [verilog/code_protect_and_id_space.sv]
// Access control for program flash and the identification / factory space.
// Assumes flash array and programming engine sit outside; this block gates
// requests and muxes read data. Single clock, synchronous reset.
//
// Contract
// - Code protection on: external program writes blocked, external program reads return zero.
// - Code protect bit is bit 0 of the fifth config word, active low.
// - Config word five bits 13 to 1 always read as ones.
// - CPU fetches and reads of program memory ignore code protection.
// - Self-writes are gated only by the addressed region's write protection.
// - Four independent write-protect bits: application, storage flash, boot, config.
// - Each region write-protect bit is active low.
// - A cleared write-protect bit stays cleared until reset or bulk erase.
// - Four user ID words at 8000h to 8003h.
// - User ID words are readable and writable during normal execution.
// - Read-only 14-bit device ID at 8006h, revision at 8005h.
// - Revision bits 13 and 12 read as fixed pattern 10.
// - Revision holds major in bits 11-6, minor in bits 5-0.
// - ID, revision and config words readable by software via NVM control.
// - External tools may read ID, revision and config words.
// - Factory area 8100h to 811Fh is read-only and never altered.
// - Factory area holds temperature readings at 8113h and 8116h.
// - Factory area holds six reference millivolt words at 8118h to 811Dh.
// - Low-voltage variants leave the two 4x reference words empty.
`timescale 1ns/100ps
module code_protect_and_id_space
   import code_protect_pkg::*;
#(
   // Arbitrary neutral identification values
   parameter logic [13:0] DEVICE_ID     = 14'h0123,
   parameter logic [5:0]  MAJOR_REV     = 6'h01,
   parameter logic [5:0]  MINOR_REV     = 6'h00,
   parameter logic        LOW_VOLTAGE   = 1'b0,
   parameter logic [13:0] TEMP_LOW_CAL  = 14'h0200,
   parameter logic [13:0] TEMP_HIGH_CAL = 14'h0180,
   parameter logic [13:0] ADC_REF_1X    = 14'h0400,
   parameter logic [13:0] ADC_REF_2X    = 14'h0800,
   parameter logic [13:0] ADC_REF_4X    = 14'h1000,
   parameter logic [13:0] CMP_REF_1X    = 14'h0400,
   parameter logic [13:0] CMP_REF_2X    = 14'h0800,
   parameter logic [13:0] CMP_REF_4X    = 14'h1000
) (
   input  wire logic        sys_clk,
   input  wire logic        resetn,
   // Bulk erase restores all protection bits
   input  wire logic        bulkErase,
   // CPU / NVM control register side
   input  wire logic        cpuReq,
   input  wire logic        cpuWrite,
   input  wire logic [15:0] cpuAddr,
   input  wire logic [13:0] cpuWdata,
   input  wire region_t     cpuRegion,
   output logic             cpuAck,
   output logic [13:0]      cpuRdata,
   // External programmer side
   input  wire logic        extReq,
   input  wire logic        extWrite,
   input  wire logic [15:0] extAddr,
   input  wire logic [13:0] extWdata,
   output logic             extAck,
   output logic [13:0]      extRdata,
   // Flash array interface
   input  wire logic [13:0] flashRdata,
   output logic             flashWrite,
   output logic [15:0]      flashAddr,
   output logic [13:0]      flashWdata,
   // Status
   output logic             writeRefused,
   output logic             protectActive
);

   // Configuration state
   logic [13:0] cfgMemory_q;
   logic        codeProtectN_q;
   logic [13:0] userId_q [0:3];

   // Address classification, shared by both requesters
   function automatic logic isUserId(input logic [15:0] a);
      return (a >= USER_ID_FIRST) && (a <= USER_ID_LAST);
   endfunction

   function automatic logic isIdSpace(input logic [15:0] a);
      return a[15];
   endfunction

   // ID-space read mux; unmapped ID-space words read as zero
   function automatic logic [13:0] idRead(input logic [15:0] a,
                                         input logic [13:0] cfg4,
                                         input logic        cpn,
                                         input logic [13:0] uid);
      logic [13:0] v;
      v = 14'h0000;
      if (isUserId(a)) begin
         v = uid;
      end else if (a == REVISION_ADDR) begin
         v = {REV_FIXED, MAJOR_REV, MINOR_REV};
      end else if (a == DEVICE_ID_ADDR) begin
         v = DEVICE_ID;
      end else if (a == CONFIG4_ADDR) begin
         v = cfg4;
      end else if (a == PROT_CFG_ADDR) begin
         v = {PROT_SPARE_ONES, cpn};
      end else if (a == TEMP_LOW_ADDR) begin
         v = TEMP_LOW_CAL;
      end else if (a == TEMP_HIGH_ADDR) begin
         v = TEMP_HIGH_CAL;
      end else if (a >= REF_FIRST_ADDR && a <= REF_LAST_ADDR) begin
         // 4x words are unpopulated on low-voltage parts
         case (a[2:0])
            3'h0: v = ADC_REF_1X;
            3'h1: v = ADC_REF_2X;
            3'h2: v = LOW_VOLTAGE ? 14'h0000 : ADC_REF_4X;
            3'h3: v = CMP_REF_1X;
            3'h4: v = CMP_REF_2X;
            3'h5: v = LOW_VOLTAGE ? 14'h0000 : CMP_REF_4X;
            default: v = 14'h0000;
         endcase
      end
      return v;
   endfunction

   // Region write-protect bit lookup, active low
   function automatic logic regionWritable(input region_t r, input logic [13:0] cfg4);
      case (r)
         REGION_APP:  return cfg4[WP_APP_BIT];
         REGION_STORE: return cfg4[WP_STORE_BIT];
         REGION_BOOT: return cfg4[WP_BOOT_BIT];
         REGION_CFG:  return cfg4[WP_CFG_BIT];
         default:     return 1'b0;
      endcase
   endfunction

   // Config words, the ID-space words in which a write can only clear bits
   function automatic logic isCfgWord(input logic [15:0] a);
      return (a == CONFIG4_ADDR) || (a == PROT_CFG_ADDR);
   endfunction

   // Read-only words of the identification space; writes there vanish
   function automatic logic isReadOnly(input logic [15:0] a);
      return isIdSpace(a) && !isUserId(a) && !isCfgWord(a);
   endfunction

   // Request gating and config update terms
   logic        cpuWriteOk;
   logic        extWriteOk;
   logic        extGrant;
   logic        cpuCfgWrite;
   logic        extCfgWrite;
   logic [15:0] cfgAddr;
   logic [13:0] cfgWdata;
   logic        cpuRefused;
   logic        extRefused;

   // CPU wins the shared port; the programmer waits for an idle cycle
   always_comb begin
      extGrant = extReq && !cpuReq;
   end

   // Write gating: CPU by region only, external by code protection only
   // Keeping the two apart lets a bootloader update itself on a locked part
   always_comb begin
      cpuWriteOk = cpuReq && cpuWrite && regionWritable(cpuRegion, cfgMemory_q);
      extWriteOk = extGrant && extWrite && codeProtectN_q;
   end

   // Config word update terms; the grant keeps the requesters exclusive
   always_comb begin
      cpuCfgWrite = cpuWriteOk && isCfgWord(cpuAddr);
      extCfgWrite = extWriteOk && isCfgWord(extAddr);
      cfgAddr     = cpuCfgWrite ? cpuAddr : extAddr;
      cfgWdata    = cpuCfgWrite ? cpuWdata : extWdata;
   end

   // Refusal terms; read-only words are dropped silently instead
   // A flag there would let software probe the factory map by writing
   always_comb begin
      cpuRefused = cpuReq && cpuWrite && !cpuWriteOk && !isReadOnly(cpuAddr);
      extRefused = extGrant && extWrite && !extWriteOk && !isReadOnly(extAddr);
   end

   // Memory config word: protection bits only clear until reset or bulk erase
   // Reset and erase both give all ones, every region writable
   always_ff @(posedge sys_clk) begin
      if (!resetn || bulkErase) begin
         cfgMemory_q <= CONFIG4_RESET;
      end else if ((cpuCfgWrite || extCfgWrite) && cfgAddr == CONFIG4_ADDR) begin
         cfgMemory_q <= cfgMemory_q & cfgWdata;
      end
   end

   // Code protect bit, sticky so a tool cannot unlock a protected part
   always_ff @(posedge sys_clk) begin
      if (!resetn || bulkErase) begin
         codeProtectN_q <= 1'b1;
      end else if ((cpuCfgWrite || extCfgWrite) && cfgAddr == PROT_CFG_ADDR) begin
         codeProtectN_q <= codeProtectN_q & cfgWdata[PROT_BIT];
      end
   end

   // User ID words, writable from CPU, or externally when unprotected
   // Reset value matches an erased word
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         for (int i = 0; i < 4; i++) begin
            userId_q[i] <= 14'h3fff;
         end
      end else if (cpuWriteOk && isUserId(cpuAddr)) begin
         userId_q[cpuAddr[1:0]] <= cpuWdata;
      end else if (extWriteOk && isUserId(extAddr)) begin
         userId_q[extAddr[1:0]] <= extWdata;
      end
   end

   // CPU answer strobe, one cycle after each request
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         cpuAck <= 1'b0;
      end else begin
         cpuAck <= cpuReq;
      end
   end

   // CPU read data, never blocked by code protection
   // Flash data is taken as is for the address of this cycle
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         cpuRdata <= 14'h0000;
      end else if (isIdSpace(cpuAddr)) begin
         cpuRdata <= idRead(cpuAddr, cfgMemory_q, codeProtectN_q,
                            userId_q[cpuAddr[1:0]]);
      end else begin
         cpuRdata <= flashRdata;
      end
   end

   // Programmer answer strobe, granted requests only
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         extAck <= 1'b0;
      end else begin
         extAck <= extGrant;
      end
   end

   // Programmer read data: program memory zeroed when protected
   // ID space stays visible so a tool can still identify a locked part
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         extRdata <= 14'h0000;
      end else if (isIdSpace(extAddr)) begin
         extRdata <= idRead(extAddr, cfgMemory_q, codeProtectN_q,
                            userId_q[extAddr[1:0]]);
      end else if (!codeProtectN_q) begin
         extRdata <= 14'h0000;
      end else begin
         extRdata <= flashRdata;
      end
   end

   // Flash write strobe; ID space writes never reach the array
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         flashWrite <= 1'b0;
      end else begin
         flashWrite <= (cpuWriteOk && !isIdSpace(cpuAddr))
                       || (extWriteOk && !isIdSpace(extAddr));
      end
   end

   // Flash address and data follow whichever requester has the port
   // They also move on reads; only the strobe qualifies them
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         flashAddr  <= 16'h0000;
         flashWdata <= 14'h0000;
      end else begin
         flashAddr  <= cpuReq ? cpuAddr : extAddr;
         flashWdata <= cpuReq ? cpuWdata : extWdata;
      end
   end

   // One-cycle refusal pulse for blocked writes
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         writeRefused <= 1'b0;
      end else begin
         writeRefused <= cpuRefused || extRefused;
      end
   end

   // Status level of code protection, one cycle behind the bit
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         protectActive <= 1'b0;
      end else begin
         protectActive <= !codeProtectN_q;
      end
   end

endmodule

// [verification/code_protect_sva.sv]
// Port checker for the protection and identification block.
// Assumes binding to the top module; single clock domain.
`timescale 1ns/100ps
module code_protect_sva
   import code_protect_pkg::*;
#(
   parameter logic [13:0] DEVICE_ID = 14'h0123
) (
   input wire logic        sys_clk,
   input wire logic        resetn,
   input wire logic        cpuReq,
   input wire logic        cpuWrite,
   input wire logic [15:0] cpuAddr,
   input wire logic        cpuAck,
   input wire logic [13:0] cpuRdata,
   input wire logic        extReq,
   input wire logic        extWrite,
   input wire logic [15:0] extAddr,
   input wire logic        extAck,
   input wire logic [13:0] extRdata,
   input wire logic        flashWrite,
   input wire logic        writeRefused,
   input wire logic        protectActive
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   // Plain CPU read and protected external program access
   wire logic rd = cpuReq && !cpuWrite;
   wire logic ep = protectActive && extReq && !cpuReq && !extAddr[15];
   chk_cpu_ack: assert property (cpuReq |=> cpuAck)
      else $error("cpu request not answered");
   chk_ext_ack: assert property (extReq && !cpuReq |=> extAck)
      else $error("ext request not answered");
   chk_ext_zero: assert property (ep && !extWrite |=> extRdata == 14'h0000)
      else $error("protected ext read not zero");
   chk_ext_block: assert property (ep && extWrite |=> writeRefused && !flashWrite)
      else $error("protected ext write not blocked");
   chk_dev_id: assert property (rd && cpuAddr == DEVICE_ID_ADDR |=> cpuRdata == DEVICE_ID)
      else $error("device ident wrong");
   chk_rev_fixed: assert property (rd && cpuAddr == REVISION_ADDR
      |=> cpuRdata[13:12] == 2'b10)
      else $error("revision fixed bits wrong");
   chk_cfg5_ones: assert property (rd && cpuAddr == PROT_CFG_ADDR
      |=> cpuRdata[13:1] == PROT_SPARE_ONES)
      else $error("config five spare bits not ones");
   chk_ro_silent: assert property (cpuReq && cpuWrite && (cpuAddr inside {[REVISION_ADDR:DEVICE_ID_ADDR],
      [FACTORY_FIRST:FACTORY_LAST]}) |=> !writeRefused && !flashWrite)
      else $error("read-only write not silent");
   cover property (writeRefused && !protectActive);
   cover property (protectActive && extAck);
   cover property (flashWrite && cpuAck);
endmodule

bind code_protect_and_id_space code_protect_sva #(.DEVICE_ID(DEVICE_ID)) i_sva (
   .sys_clk, .resetn, .cpuReq, .cpuWrite, .cpuAddr, .cpuAck, .cpuRdata, .extReq,
   .extWrite, .extAddr, .extAck, .extRdata, .flashWrite, .writeRefused, .protectActive);

// [verification/prog_tool_model.sv]
// Programmer-side model issuing one-word requests on the external port.
// Assumes a one-cycle registered answer from the block.
`timescale 1ns/100ps
module prog_tool_model (
   input  wire logic        sys_clk,
   input  wire logic        extAck,
   input  wire logic [13:0] extRdata,
   output logic             extReq,
   output logic             extWrite,
   output logic [15:0]      extAddr,
   output logic [13:0]      extWdata
);
   logic [13:0] q;
   // Idle levels at time zero
   initial begin
      extReq = 1'b0;
      extWrite = 1'b0;
      extAddr = 16'h0000;
      extWdata = 14'h0000;
   end
   // Request pulse, then address and data flip so no stale address or data lingers
   task automatic rw(input logic w, input logic [15:0] a, input logic [13:0] d);
      @(posedge sys_clk);
      extReq <= 1'b1;
      extWrite <= w;
      extAddr <= a;
      extWdata <= d;
      @(posedge sys_clk);
      extReq <= 1'b0;
      extAddr <= ~a;
      extWdata <= ~d;
      #1;
      q = extAck ? extRdata : ~extRdata;
   endtask
endmodule

// [verification/code_protect_and_id_space_tb.sv]
// Bench for the protection block with a programmer model on the far side.
// Assumes package and design compile first.
`timescale 1ns/100ps
module code_protect_and_id_space_tb
   import code_protect_pkg::*;
;
   localparam logic [13:0] ID_VAL = 14'h0abc; // Arbitrary value
   localparam logic [13:0] FAC [14] = '{0, 'h0155, 0, 0, 'h02aa, 0, 'h0401, 'h0802,
                                        0, 'h0403, 'h0804, 0, 0, 0};
   logic        sys_clk = 0, resetn = 0, bulkErase = 0, cpuReq = 0, cpuWrite = 0;
   logic [15:0] cpuAddr = 0, extAddr, flashAddr;
   logic [13:0] cpuWdata = 0, flashRdata = 0, cpuRdata, extRdata, extWdata, flashWdata, q;
   logic        cpuAck, extReq, extWrite, extAck, flashWrite, writeRefused, protectActive;
   region_t     cpuRegion = REGION_APP;
   int          bad_count = 0, num_checks = 0, seed = 85, cyc = 0, uid [4];
   int          wb [4] = '{WP_APP_BIT, WP_STORE_BIT, WP_BOOT_BIT, WP_CFG_BIT};
   logic [3:0]  wp;
   code_protect_and_id_space #(.DEVICE_ID(ID_VAL), .MAJOR_REV(6'h05), .MINOR_REV(6'h2a),
      .LOW_VOLTAGE(1'b1), .TEMP_LOW_CAL(FAC[1]), .TEMP_HIGH_CAL(FAC[4]), .ADC_REF_1X(FAC[6]),
      .ADC_REF_2X(FAC[7]), .CMP_REF_1X(FAC[9]), .CMP_REF_2X(FAC[10])) i_dut (.sys_clk,
      .resetn, .bulkErase, .cpuReq, .cpuWrite, .cpuAddr, .cpuWdata, .cpuRegion, .cpuAck,
      .cpuRdata, .extReq, .extWrite, .extAddr, .extWdata, .extAck, .extRdata, .flashRdata,
      .flashWrite, .flashAddr, .flashWdata, .writeRefused, .protectActive);
   prog_tool_model i_tool (.sys_clk, .extAck, .extRdata, .extReq, .extWrite, .extAddr,
      .extWdata);
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   // CPU request pulse; answer sampled once it has landed
   task automatic cpu(input logic w, input logic [15:0] a, input logic [13:0] d, input region_t r);
      @(posedge sys_clk);
      cpuReq <= 1'b1;
      cpuWrite <= w;
      cpuAddr <= a;
      cpuWdata <= d;
      cpuRegion <= r;
      @(posedge sys_clk);
      cpuReq <= 1'b0;
      #1 q = cpuRdata;
      chk("cpuAck", 1, cpuAck);
   endtask
   always #10 sys_clk = ~sys_clk;
   // Hang guard, far above the roughly 140 cycles needed
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         bad_count++;
         conclude();
      end
   end
   initial begin
      @(posedge sys_clk) flashRdata <= 14'($random(seed));
      repeat (9) @(posedge sys_clk);
      resetn <= 1'b1;
      #1 chk("rstOut", 0, {cpuAck, extAck, flashWrite, writeRefused, protectActive});
      cpu(0, DEVICE_ID_ADDR, 0, REGION_APP);
      chk("device_ident_word", ID_VAL, q);
      cpu(0, REVISION_ADDR, 0, REGION_APP);
      chk("rev", {2'b10, 6'h05, 6'h2a}, q);
      cpu(0, PROT_CFG_ADDR, 0, REGION_APP);
      chk("cfg5", 14'h3fff, q);
      for (int i = 0; i < 14; i++) begin
         cpu(0, 16'h8112 + 16'(i), 0, REGION_APP);
         chk("factory", FAC[i], q);
      end
      cpu(1, DEVICE_ID_ADDR, 14'h1555, REGION_CFG);
      chk("idWr", 0, {flashWrite, writeRefused});
      cpu(1, TEMP_LOW_ADDR, 14'h1555, REGION_CFG);
      chk("facWr", 0, {flashWrite, writeRefused});
      cpu(0, DEVICE_ID_ADDR, 0, REGION_APP);
      chk("devidKept", ID_VAL, q);
      cpu(0, TEMP_LOW_ADDR, 0, REGION_APP);
      chk("facKept", FAC[1], q);
      for (int i = 0; i < 4; i++) begin
         uid[i] = $random(seed) & 'h3fff;
         cpu(1, USER_ID_FIRST + 16'(i), 14'(uid[i]), REGION_CFG);
      end
      i_tool.rw(1, USER_ID_LAST, 14'h1234);
      uid[3] = 'h1234;
      for (int i = 0; i < 4; i++) begin
         cpu(0, USER_ID_FIRST + 16'(i), 0, REGION_APP);
         chk("uid", uid[i], q);
      end
      i_tool.rw(1, 16'h0010, 14'h2a5a);
      chk("extWr", {1'b1, 16'h0010, 14'h2a5a}, {flashWrite, flashAddr, flashWdata});
      i_tool.rw(0, 16'h0010, 0);
      chk("extRd", flashRdata, i_tool.q);
      i_tool.rw(0, DEVICE_ID_ADDR, 0);
      chk("extId", ID_VAL, i_tool.q);
      // Clear one region at a time; config region last so earlier writes land
      wp = 4'hf;
      for (int k = 0; k < 4; k++) begin
         wp[k] = 1'b0;
         cpu(1, CONFIG4_ADDR, 14'h3fff & ~(14'h1 << wb[k]), REGION_CFG);
         for (int r = 0; r < 4; r++) begin
            cpu(1, 16'h0020, 14'h0001, region_t'(r));
            chk("wp", {!wp[r], wp[r]}, {writeRefused, flashWrite});
         end
      end
      // Programmer write is not region gated, so only stickiness keeps the bits
      i_tool.rw(1, CONFIG4_ADDR, 14'h3fff);
      cpu(0, CONFIG4_ADDR, 0, REGION_CFG);
      chk("sticky", 0, {q[wb[0]], q[wb[1]], q[wb[2]], q[wb[3]]});
      @(posedge sys_clk) bulkErase <= 1'b1;
      @(posedge sys_clk) bulkErase <= 1'b0;
      cpu(0, CONFIG4_ADDR, 0, REGION_CFG);
      chk("erased", CONFIG4_RESET, q);
      cpu(1, PROT_CFG_ADDR, 14'h0000, REGION_CFG);
      repeat (2) @(posedge sys_clk);
      #1 chk("protect", 1, protectActive);
      cpu(0, PROT_CFG_ADDR, 0, REGION_APP);
      chk("cfg5On", 14'h3ffe, q);
      i_tool.rw(0, 16'h0010, 0);
      chk("extZero", 0, i_tool.q);
      i_tool.rw(1, 16'h0010, 14'h0003);
      chk("extBlk", 2'b01, {flashWrite, writeRefused});
      cpu(0, 16'h0010, 0, REGION_APP);
      chk("cpuRd", flashRdata, q);
      cpu(1, 16'h0030, 14'h0007, REGION_STORE);
      chk("selfWr", 1, flashWrite);
      i_tool.rw(0, DEVICE_ID_ADDR, 0);
      chk("extIdCp", ID_VAL, i_tool.q);
      conclude();
   end
endmodule
